//--- rtl/tester_status_pkg.sv
// ****************************************************************************
// Register selection codes, bit positions, used-bit masks and reset values.
// ****************************************************************************
package tester_status_pkg;

    // Register width.
    localparam int unsigned DATA_W = 8;

    // Register selection codes on the query and write ports.
    typedef enum logic [3:0]
    {
        SEL_STATUS_BYTE = 4'h0,
        SEL_SRQ_MASK    = 4'h1,
        SEL_EVENT       = 4'h2,
        SEL_COND        = 4'h3,
        SEL_COND_MASK   = 4'h4,
        SEL_TRIP        = 4'h5,
        SEL_REJECT      = 4'h6,
        SEL_CONFIG      = 4'h7,
        SEL_MSG_ERR     = 4'h8
    } reg_sel_e;

    // Status summary byte bit positions.
    localparam int unsigned STB_RQS_BIT = 6;
    localparam int unsigned STB_ESB_BIT = 5;
    localparam int unsigned STB_DSB_BIT = 4;

    // Standard event bit positions.
    localparam int unsigned EVT_CMD_ERR_BIT = 5;
    localparam int unsigned EVT_EXE_ERR_BIT = 4;

    // Device condition bit positions, shared by the flags and their mask.
    localparam int unsigned COND_TRIP_BIT = 7;
    localparam int unsigned COND_STOP_BIT = 6;
    localparam int unsigned COND_FAIL_BIT = 5;
    localparam int unsigned COND_PASS_BIT = 4;
    localparam int unsigned COND_ARMED_BIT = 3;
    localparam int unsigned COND_CURRENT_BIT = 2;
    localparam int unsigned COND_BADCFG_BIT = 1;
    localparam int unsigned COND_READY_BIT = 0;

    // Safety trip bit positions.
    localparam int unsigned TRIP_AMP_BIT = 5;
    localparam int unsigned TRIP_EXTEN_BIT = 4;
    localparam int unsigned TRIP_CLAMP_BIT = 3;
    localparam int unsigned TRIP_OVERLOAD_BIT = 2;
    localparam int unsigned TRIP_HEAT_TIMER_BIT = 1;
    localparam int unsigned TRIP_HEAT_BIT = 0;

    // Judgment reject bit positions.
    localparam int unsigned REJ_UPPER_BIT = 2;
    localparam int unsigned REJ_LOWER_BIT = 1;

    // Bad configuration bit positions.
    localparam int unsigned CFG_RESIST_BIT = 3;
    localparam int unsigned CFG_POWER_BIT = 2;
    localparam int unsigned CFG_INVERTED_BIT = 1;
    localparam int unsigned CFG_VOLT_BIT = 0;

    // Message error bit positions.
    localparam int unsigned ERR_DISALLOWED_BIT = 3;
    localparam int unsigned ERR_RANGE_BIT = 2;
    localparam int unsigned ERR_DATA_BIT = 1;
    localparam int unsigned ERR_SYNTAX_BIT = 0;

    // Masks of the bits that exist in each register except the condition flags and their mask.
    localparam logic [7:0] STB_USED = 8'h70;
    localparam logic [7:0] SRQ_MASK_USED = 8'h30;
    localparam logic [7:0] EVT_USED = 8'h30;
    localparam logic [7:0] TRIP_USED = 8'h3F;
    localparam logic [7:0] REJECT_USED = 8'h06;
    localparam logic [7:0] CONFIG_USED = 8'h0F;
    localparam logic [7:0] MSG_ERR_USED = 8'h0F;

    // Reset value of every register.
    localparam logic [7:0] REG_RESET = 8'h00;

endpackage

//--- rtl/tester_status_reporting.sv
// Notes on behaviour
// - Service request shows in status bit 6; a serial poll clears it.
// - Status query bit 6 is the OR of status bits gated by their enable.
// - Status bit 5 is set whenever any standard event bit is set.
// - Status bit 4 is set whenever any device condition bit is set.
// - Event bit 5 sets on syntax, data or out-of-range message errors.
// - Event bit 4 sets on a disallowed message during test or trip.
// - Condition flags and mask share one layout: trip, stop, fail, pass, armed, current, bad config, ready.
// - Condition bit 3 sets while contact check armed, standby and current flows.
// - Condition bit 2 sets while test current flows.
// - Condition bit 1 sets while any bad configuration is shown.
// - Trip bit 5 sets when output current deviates over ten percent.
// - Trip bit 4 sets when the external enable input changes state.
// - Trip bit 3 sets when output voltage is clamped at its limit.
// - Trip bits 2, 1, 0 flag overload, heat timer and temperature.
// - Reject bit 2 sets on failure above the upper reference.
// - Reject bit 1 sets on failure against the lower reference.
// - Config bit 3 sets when settings exceed the resistance range.
// - Config bit 2 sets when settings exceed the power limit.
// - Config bit 1 sets when lower limit lies above upper reference.
// - Config bit 0 sets when the implied test voltage is too high.
// - Error bit 3 sets on a message not allowed in the present state.
// - Error bits 2, 1, 0 flag out-of-range, data and header errors.
// - Event register query returns its value, then clears it.
// - Clear-status clears the status byte and all flag registers together.
`timescale 1ns/1ps
`default_nettype none

module tester_status_reporting
    import tester_status_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Host query, serial poll, clear and mask write strobes.
    input wire logic query_valid,
    input wire logic [3:0] query_sel,
    input wire logic poll_valid,
    input wire logic clear_status,
    input wire logic wr_valid,
    input wire logic [3:0] wr_sel,
    input wire logic [7:0] wr_data,
    // Message parser events, one-cycle pulses.
    input wire logic syntax_err_evt,
    input wire logic data_err_evt,
    input wire logic range_err_evt,
    input wire logic disallowed_msg_evt,
    // Test state levels.
    input wire logic safety_trip_state,
    input wire logic test_stopped,
    input wire logic fail_judged,
    input wire logic pass_judged,
    input wire logic contact_check_on,
    input wire logic contact_standby,
    input wire logic test_current_on,
    input wire logic ready_state,
    // Protection conditions.
    input wire logic amp_deviation,
    input wire logic ext_enable,
    input wire logic voltage_clamp,
    input wire logic overload_trip,
    input wire logic heat_timer_trip,
    input wire logic heat_trip,
    // Judgment results.
    input wire logic upper_fail,
    input wire logic lower_fail,
    // Configuration checks.
    input wire logic resistance_range_exceeded,
    input wire logic power_limit_exceeded,
    input wire logic limits_inverted,
    input wire logic voltage_setting_exceeded,
    // Answers to the host.
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic service_request
);

    // ************************************************************************
    // Storage.
    // ************************************************************************

    logic [7:0] srq_mask_r;
    logic [7:0] event_r;
    logic [7:0] cond_r;
    logic [7:0] cond_mask_r;
    logic [7:0] trip_r;
    logic [7:0] reject_r;
    logic [7:0] config_r;
    logic [7:0] msg_err_r;
    logic rqs_r;
    logic mss_prev_r;
    logic ext_enable_prev_r;
    logic primed_r;
    logic [7:0] rd_data_r;
    logic rd_valid_r;

    // ************************************************************************
    // Set vectors from the internal conditions.
    // ************************************************************************

    logic any_cmd_err;
    logic exe_err;
    logic bad_config_state;
    logic ext_enable_changed;
    logic [7:0] event_set;
    logic [7:0] cond_set;
    logic [7:0] trip_set;
    logic [7:0] reject_set;
    logic [7:0] config_set;
    logic [7:0] msg_err_set;

    // Command and execution errors feed the standard event flags.
    assign any_cmd_err = syntax_err_evt | data_err_evt | range_err_evt;
    assign exe_err = disallowed_msg_evt & (test_current_on | safety_trip_state);
    assign event_set = ({7'h00, any_cmd_err} << EVT_CMD_ERR_BIT)
                     | ({7'h00, exe_err} << EVT_EXE_ERR_BIT);

    // Any bad configuration shown on the display raises condition bit 1.
    assign bad_config_state = resistance_range_exceeded | power_limit_exceeded
                            | limits_inverted | voltage_setting_exceeded;

    // Device condition flags, one bit per documented state.
    assign cond_set = {safety_trip_state, test_stopped, fail_judged, pass_judged,
                       contact_check_on & contact_standby & test_current_on,
                       test_current_on,
                       bad_config_state, ready_state};

    // The enable input change is only seen once a previous sample exists.
    assign ext_enable_changed = primed_r & (ext_enable ^ ext_enable_prev_r);

    // Protection flags; bits 7 and 6 stay zero.
    assign trip_set = {2'b00,
                       amp_deviation,
                       ext_enable_changed,
                       voltage_clamp,
                       overload_trip, heat_timer_trip, heat_trip};

    // Judgment reject flags.
    assign reject_set = {5'h00, upper_fail, lower_fail, 1'b0};

    // Bad configuration flags.
    assign config_set = {4'h0,
                         resistance_range_exceeded,
                         power_limit_exceeded,
                         limits_inverted,
                         voltage_setting_exceeded};

    // Message error flags.
    assign msg_err_set = {4'h0, disallowed_msg_evt,
                          range_err_evt, data_err_evt, syntax_err_evt};

    // ************************************************************************
    // Clear and write decode.
    // ************************************************************************

    logic poll_take;
    logic query_take;
    logic event_read_clr;
    logic srq_mask_wr;
    logic cond_mask_wr;

    // A serial poll wins over a query offered in the same cycle.
    assign poll_take = poll_valid;
    assign query_take = query_valid & ~poll_valid;
    assign event_read_clr = query_take & (query_sel == SEL_EVENT);
    assign srq_mask_wr = wr_valid & (wr_sel == SEL_SRQ_MASK);
    assign cond_mask_wr = wr_valid & (wr_sel == SEL_COND_MASK);

    // ************************************************************************
    // Next values of the sticky flags; a set always beats a clear.
    // ************************************************************************

    logic [7:0] event_nxt;
    logic [7:0] cond_nxt;
    logic [7:0] trip_nxt;
    logic [7:0] reject_nxt;
    logic [7:0] config_nxt;
    logic [7:0] msg_err_nxt;

    // Clear-status empties every flag register at once.
    assign event_nxt = (((clear_status | event_read_clr) ? REG_RESET : event_r)
                       | event_set) & EVT_USED;
    assign cond_nxt = (clear_status ? REG_RESET : cond_r) | cond_set;
    assign trip_nxt = ((clear_status ? REG_RESET : trip_r) | trip_set) & TRIP_USED;
    assign reject_nxt = ((clear_status ? REG_RESET : reject_r) | reject_set) & REJECT_USED;
    assign config_nxt = ((clear_status ? REG_RESET : config_r) | config_set) & CONFIG_USED;
    assign msg_err_nxt = ((clear_status ? REG_RESET : msg_err_r) | msg_err_set) & MSG_ERR_USED;

    // ************************************************************************
    // Status summary byte.
    // ************************************************************************

    logic esb;
    logic dsb;
    logic [7:0] stb_low;
    logic mss;
    logic mss_rise;
    logic rqs_nxt;

    // Summary bits follow the flag registers.
    assign esb = |event_r;
    assign dsb = |cond_r;
    assign stb_low = ({7'h00, esb} << STB_ESB_BIT) | ({7'h00, dsb} << STB_DSB_BIT);

    // Master summary: status bits gated by their enable, unused bits excluded.
    assign mss = |(stb_low & srq_mask_r & SRQ_MASK_USED);
    assign mss_rise = mss & ~mss_prev_r;

    // Request is raised on a new summary; poll or clear-status drops it.
    assign rqs_nxt = mss_rise | (rqs_r & ~poll_take & ~clear_status);

    // ************************************************************************
    // Read data selection.
    // ************************************************************************

    logic [7:0] stb_query;
    logic [7:0] stb_poll;
    logic [7:0] query_data;
    logic [7:0] rd_data_nxt;

    // Query shows the live summary, poll shows the latched request.
    assign stb_query = stb_low | ({7'h00, mss} << STB_RQS_BIT);
    assign stb_poll = stb_low | ({7'h00, rqs_r} << STB_RQS_BIT);

    // Register selected by the query; unknown codes read zero.
    assign query_data = (query_sel == SEL_STATUS_BYTE) ? stb_query
                      : (query_sel == SEL_SRQ_MASK) ? srq_mask_r
                      : (query_sel == SEL_EVENT) ? event_r
                      : (query_sel == SEL_COND) ? cond_r
                      : (query_sel == SEL_COND_MASK) ? cond_mask_r
                      : (query_sel == SEL_TRIP) ? trip_r
                      : (query_sel == SEL_REJECT) ? reject_r
                      : (query_sel == SEL_CONFIG) ? config_r
                      : (query_sel == SEL_MSG_ERR) ? msg_err_r
                      : REG_RESET;
    assign rd_data_nxt = poll_take ? stb_poll : (query_take ? query_data : rd_data_r);

    // ************************************************************************
    // Registers.
    // ************************************************************************

    // Host-written enable masks.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            srq_mask_r <= REG_RESET;
            cond_mask_r <= REG_RESET;
        end
        else
        begin
            if (srq_mask_wr)
                srq_mask_r <= wr_data & SRQ_MASK_USED;
            if (cond_mask_wr)
                cond_mask_r <= wr_data;
        end
    end

    // Sticky flag registers.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            event_r <= REG_RESET;
            cond_r <= REG_RESET;
            trip_r <= REG_RESET;
            reject_r <= REG_RESET;
            config_r <= REG_RESET;
            msg_err_r <= REG_RESET;
        end
        else
        begin
            event_r <= event_nxt;
            cond_r <= cond_nxt;
            trip_r <= trip_nxt;
            reject_r <= reject_nxt;
            config_r <= config_nxt;
            msg_err_r <= msg_err_nxt;
        end
    end

    // Request latch and edge history.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rqs_r <= 1'b0;
            mss_prev_r <= 1'b0;
            ext_enable_prev_r <= 1'b0;
            primed_r <= 1'b0;
        end
        else
        begin
            rqs_r <= rqs_nxt;
            mss_prev_r <= mss;
            ext_enable_prev_r <= ext_enable;
            primed_r <= 1'b1;
        end
    end

    // Answer to the host, one cycle after the strobe.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_r <= REG_RESET;
            rd_valid_r <= 1'b0;
        end
        else
        begin
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= poll_take | query_take;
        end
    end

    // Outputs come straight from flip-flops.
    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign service_request = rqs_r;

    // ************************************************************************
    // Assertions.
    // ************************************************************************

    // A poll without a new summary edge leaves no request behind.
    property p_poll_clears;
        @(posedge clk) disable iff (!rst_n)
        poll_valid && !mss_rise |=> !service_request && rd_valid;
    endproperty
    a_poll_clears: assert property (p_poll_clears)
        else $error("Service request survived a serial poll.");

    // Status query bit 6 carries the gated summary of the sampled cycle.
    property p_query_mss;
        @(posedge clk) disable iff (!rst_n)
        query_valid && !poll_valid && query_sel == SEL_STATUS_BYTE
        |=> rd_data[STB_RQS_BIT] == $past(mss) && rd_data[STB_ESB_BIT] == $past(|event_r);
    endproperty
    a_query_mss: assert property (p_query_mss)
        else $error("Status query summary bits are wrong.");

    // A syntax error reaches event bit 5 and a status summary bit 5.
    property p_cmd_err;
        @(posedge clk) disable iff (!rst_n)
        syntax_err_evt
        |=> event_r[EVT_CMD_ERR_BIT] ##1 (esb || $past(event_read_clr || clear_status));
    endproperty
    a_cmd_err: assert property (p_cmd_err)
        else $error("Command error not recorded.");

    // A disallowed message during a test sets the execution error.
    property p_exe_err;
        @(posedge clk) disable iff (!rst_n)
        disallowed_msg_evt && test_current_on
        |=> event_r[EVT_EXE_ERR_BIT] && msg_err_r[ERR_DISALLOWED_BIT];
    endproperty
    a_exe_err: assert property (p_exe_err)
        else $error("Execution error not recorded.");

    // Test current is reflected in condition bit 2.
    property p_current_flag;
        @(posedge clk) disable iff (!rst_n)
        test_current_on |=> cond_r[COND_CURRENT_BIT];
    endproperty
    a_current_flag: assert property (p_current_flag)
        else $error("Test current flag missing.");

    // A change on the enable input raises the trip bit.
    property p_enable_change;
        @(posedge clk) disable iff (!rst_n)
        primed_r && $changed(ext_enable) |=> trip_r[TRIP_EXTEN_BIT];
    endproperty
    a_enable_change: assert property (p_enable_change)
        else $error("Enable input change not recorded.");

    // An event query returns the old value and leaves the register empty.
    property p_event_read_clear;
        @(posedge clk) disable iff (!rst_n)
        query_valid && !poll_valid && query_sel == SEL_EVENT && event_set == 8'h00
        |=> rd_data == $past(event_r) && event_r == 8'h00;
    endproperty
    a_event_read_clear: assert property (p_event_read_clear)
        else $error("Event register not cleared by its query.");

    // Clear-status with no new sets empties the event, condition and trip flags and drops the request.
    property p_clear_status;
        @(posedge clk) disable iff (!rst_n)
        clear_status && !mss_rise && event_set == 8'h00 && cond_set == 8'h00
        && trip_set == 8'h00
        |=> event_r == 8'h00 && cond_r == 8'h00 && trip_r == 8'h00 && !service_request;
    endproperty
    a_clear_status: assert property (p_clear_status)
        else $error("Clear-status left flags set.");

    // Unused status byte bits never read as one, nor do unused reject or message error bits.
    property p_unused_zero;
        @(posedge clk) disable iff (!rst_n)
        rd_valid && $past(poll_valid || (query_valid && query_sel == SEL_STATUS_BYTE))
        |-> (rd_data & ~STB_USED) == 8'h00 && (reject_r & ~REJECT_USED) == 8'h00
            && (msg_err_r & ~MSG_ERR_USED) == 8'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("Unused bit read as one.");

endmodule

`default_nettype wire

//--- verif/status_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************************
// Remote host: queries, serial polls, clear-status and mask writes.
// ****************************************************************************
module status_host_model
(
    // Clock.
    input wire logic clk,
    // Requests to the device.
    output logic query_valid,
    output logic [3:0] query_sel,
    output logic poll_valid,
    output logic clear_status,
    output logic wr_valid,
    output logic [3:0] wr_sel,
    output logic [7:0] wr_data,
    // Answers from the device.
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    // Idle values; released fields show the inverse so stale data cannot match.
    initial
    begin
        {query_valid, poll_valid, clear_status, wr_valid} = 4'h0;
        query_sel = 4'hF;
        wr_sel = 4'hF;
        wr_data = 8'h00;
    end

    // Query (q=1) or serial poll (q=0); the answer is awaited for a few cycles.
    task automatic xfer(input logic q, input logic [3:0] s, output logic [7:0] d,
                        output logic ok);
        @(posedge clk);
        query_valid <= q;
        poll_valid <= ~q;
        query_sel <= s;
        @(posedge clk);
        query_valid <= 1'b0;
        poll_valid <= 1'b0;
        query_sel <= ~s;
        ok = 1'b0;
        d = 8'h00;
        // The answer stands for the single cycle after the taking edge, so look now.
        for (int i = 0; i < 4 && !ok; i++)
        begin
            #1;
            if (rd_valid === 1'b1)
            begin
                ok = 1'b1;
                d = rd_data;
            end
            else
                @(posedge clk);
        end
    endtask

    // Mask write (clr=0) or clear-status command (clr=1), one cycle each.
    task automatic cmd(input logic clr, input logic [3:0] s, input logic [7:0] v);
        @(posedge clk);
        wr_valid <= ~clr;
        clear_status <= clr;
        wr_sel <= s;
        wr_data <= v;
        @(posedge clk);
        wr_valid <= 1'b0;
        clear_status <= 1'b0;
        wr_sel <= ~s;
        wr_data <= ~v;
    endtask
endmodule

`default_nettype wire

//--- verif/tester_status_reporting_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tester_status_reporting_tb_top;
    import tester_status_pkg::*;

    logic clk, rst_n, query_valid, poll_valid, clear_status, wr_valid;
    logic rd_valid, service_request, ok;
    logic [3:0] query_sel, wr_sel, ev;
    logic [7:0] wr_data, rd_data, d;
    logic [19:0] lv;
    logic syntax_err_evt, data_err_evt, range_err_evt, disallowed_msg_evt;
    logic safety_trip_state, test_stopped, fail_judged, pass_judged, contact_check_on;
    logic contact_standby, test_current_on, ready_state, amp_deviation, ext_enable;
    logic voltage_clamp, overload_trip, heat_timer_trip, heat_trip, upper_fail, lower_fail;
    logic resistance_range_exceeded, power_limit_exceeded, limits_inverted;
    logic voltage_setting_exceeded;
    int mismatches, compares;

    // Event pulses and condition levels are packed for compact stimulus.
    assign {syntax_err_evt, data_err_evt, range_err_evt, disallowed_msg_evt} = ev;
    assign {safety_trip_state, test_stopped, fail_judged, pass_judged, contact_check_on,
            contact_standby, test_current_on, ready_state, amp_deviation, ext_enable,
            voltage_clamp, overload_trip, heat_timer_trip, heat_trip, upper_fail,
            lower_fail, resistance_range_exceeded, power_limit_exceeded,
            limits_inverted, voltage_setting_exceeded} = lv;

    tester_status_reporting u_dut (.clk, .rst_n, .query_valid, .query_sel, .poll_valid,
        .clear_status, .wr_valid, .wr_sel, .wr_data, .syntax_err_evt, .data_err_evt,
        .range_err_evt, .disallowed_msg_evt, .safety_trip_state, .test_stopped,
        .fail_judged, .pass_judged, .contact_check_on, .contact_standby, .test_current_on,
        .ready_state, .amp_deviation, .ext_enable, .voltage_clamp, .overload_trip,
        .heat_timer_trip, .heat_trip, .upper_fail, .lower_fail, .resistance_range_exceeded,
        .power_limit_exceeded, .limits_inverted, .voltage_setting_exceeded, .rd_data,
        .rd_valid, .service_request);

    status_host_model u_host (.clk, .query_valid, .query_sel, .poll_valid, .clear_status,
        .wr_valid, .wr_sel, .wr_data, .rd_data, .rd_valid);

    // ************************************************************************
    // Helpers.
    // ************************************************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Compares %0d, mismatches %0d.", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Query one register; a missing answer ends the run.
    task automatic rd(input logic [3:0] s, input logic [7:0] exp);
        u_host.xfer(1'b1, s, d, ok);
        check({7'h00, ok}, 8'h01);
        if (!ok)
            give_verdict();
        check(d, exp);
    endtask

    task automatic pulse(input logic [3:0] e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= 4'h0;
    endtask

    task automatic levels(input logic [19:0] v);
        @(posedge clk);
        lv <= v;
        repeat (2) @(posedge clk);
    endtask

    // ************************************************************************
    // Scenarios.
    // ************************************************************************
    task automatic t_reset_and_masks();
        for (int s = 0; s < 10; s++)
            rd(4'(s), 8'h00);
        u_host.cmd(1'b0, 4'h1, 8'hFF);
        rd(4'h1, 8'h30);
        u_host.cmd(1'b0, 4'h4, 8'hA5);
        rd(4'h4, 8'hA5);
        u_host.cmd(1'b0, 4'h1, 8'h20);
    endtask

    task automatic t_event_and_poll();
        pulse(4'h8);
        repeat (3) @(posedge clk);
        #1;
        check({7'h00, service_request}, 8'h01);
        rd(4'h0, 8'h60);
        rd(4'h2, 8'h20);
        rd(4'h2, 8'h00);
        u_host.xfer(1'b0, 4'h0, d, ok);
        check(d, 8'h40);
        check({7'h00, service_request}, 8'h00);
        pulse(4'h4);
        rd(4'h2, 8'h20);
        pulse(4'h2);
        rd(4'h2, 8'h20);
    endtask

    task automatic t_errors();
        rd(4'h8, 8'h07);
        pulse(4'h1);
        rd(4'h8, 8'h0F);
        rd(4'h2, 8'h00);
        levels(20'h02000);
        pulse(4'h1);
        rd(4'h2, 8'h10);
        rd(4'h0, 8'h10);
        levels(20'h00000);
    endtask

    task automatic t_levels_and_clear();
        levels(20'hAFBFF);
        rd(4'h3, 8'hAF);
        rd(4'h5, 8'h2F);
        rd(4'h6, 8'h06);
        rd(4'h7, 8'h0F);
        rd(4'h0, 8'h10);
        levels(20'hAFFFF);
        rd(4'h5, 8'h3F);
        levels(20'h00000);
        u_host.cmd(1'b1, 4'h0, 8'h00);
        for (int s = 0; s < 9; s++)
            rd(4'(s), s == 1 ? 8'h20 : (s == 4 ? 8'hA5 : 8'h00));
        levels(20'h5A000);
        rd(4'h3, 8'h54);
        levels(20'h00001);
        rd(4'h3, 8'h56);
    endtask

    // Clock source.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Reset, then the scenarios in order.
    initial
    begin
        rst_n = 1'b0;
        ev = 4'h0;
        lv = 20'h00000;
        mismatches = 0;
        compares = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_and_masks();
        t_event_and_poll();
        t_errors();
        t_levels_and_clear();
        give_verdict();
    end
endmodule

`default_nettype wire
